/* hdl/nic_regs.vh */
// Constants for the interrupt priority and pending logic.
// Assumes word-wide register accesses over the private peripheral bus.
`ifndef NIC_REGS_VH
`define NIC_REGS_VH
`define NIC_NUM_IRQ 32
`define NIC_ADDR_W 12
`define NIC_SET_ENA_OFS 12'h0100
`define NIC_CLR_ENA_OFS 12'h0180
`define NIC_SET_PEND_OFS 12'h0200
`define NIC_CLR_PEND_OFS 12'h0280
`define NIC_PRIO_BASE_OFS 12'h0400
`define NIC_PRIO_LAST_OFS 12'h041C
`define NIC_ENA_RESET 32'h0000_0000
`define NIC_PEND_RESET 32'h0000_0000
`define NIC_PRIO_RESET 2'h0
`define NIC_PRIO_HI 7
`define NIC_PRIO_LO 6
`define NIC_PRIO_MASK 8'hC0
`define NIC_NO_IRQ 6'h3F
`endif

/* hdl/nic_prio_arb.v */
// Priority arbiter: picks the most urgent enabled pending interrupt.
// Assumes priorities and request bits are stable registered inputs.
`timescale 1ns/100ps
`include "nic_regs.vh"
module nic_prio_arb
(
  input wire [`NIC_NUM_IRQ-1:0] cand, // Enabled and pending bits
  input wire [2*`NIC_NUM_IRQ-1:0] prio, // Two stored bits per irq
  output reg found, // Some candidate exists
  output reg [4:0] win_id, // Winning interrupt number
  output reg [1:0] win_prio // Winning stored priority
);
  integer i;
  // Linear scan; lower number wins ties, smaller value wins overall
  always @*
  begin
    found = 1'b0;
    win_id = 5'h00;
    win_prio = 2'h3;
    for (i = 0; i < `NIC_NUM_IRQ; i = i + 1)
    begin
      if (cand[i] && (!found || prio[2*i +: 2] < win_prio))
      begin
        found = 1'b1;
        win_id = i[4:0];
        win_prio = prio[2*i +: 2];
      end
    end
  end
endmodule

/* hdl/nic_irq_state.v */
// One interrupt's pending and active state machine.
// Assumes entry and return strobes are one-cycle pulses from the core.
`timescale 1ns/100ps
`include "nic_regs.vh"
module nic_irq_state
(
  input wire ref_clk, // System clock
  input wire rst, // Synchronous reset, active high
  input wire ce, // Clock enable
  input wire is_pulse, // High for pulse-type line
  input wire line_in, // Request line
  input wire set_pend, // Software set-pending strobe
  input wire clr_pend, // Software clear-pending strobe
  input wire enter, // Core enters this service routine
  input wire leave, // Core returns from this service routine
  output reg pend_q, // Pending state
  output reg act_q // Active state
);
  reg line_q; // Previous line sample for edge detection
  wire rise; // Low-to-high on the line
  reg pend_d;
  reg act_d;
  assign rise = line_in & ~line_q;
  // Next state; hardware set beats software clear in the same cycle
  always @*
  begin
    pend_d = pend_q;
    act_d = act_q;
    if (clr_pend)
    begin
      if (!is_pulse && line_in)
        pend_d = pend_q;
      else
        pend_d = 1'b0;
    end
    if (enter)
    begin
      pend_d = 1'b0;
      act_d = 1'b1;
    end
    if (leave)
    begin
      act_d = 1'b0;
      // Level line re-pends on return if still high
      if (!is_pulse && line_in)
        pend_d = 1'b1;
    end
    // Pulse edges pend even while active
    if (is_pulse && rise)
      pend_d = 1'b1;
    // Level line pends only while not active
    if (!is_pulse && line_in && !act_d)
      pend_d = 1'b1;
    if (set_pend)
      pend_d = 1'b1;
  end
  // State registers, frozen while clock enable is low
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      act_q <= 1'b0;
      line_q <= 1'b0;
    end
    else if (ce)
    begin
      pend_q <= pend_d;
      act_q <= act_d;
      line_q <= line_in;
    end
  end
endmodule

/* hdl/nic_top.v */
// Top of the interrupt priority and pending logic: register port,
// per-interrupt state and the forward path to the core.
// Assumes word-aligned full-word accesses and single-cycle strobes.
`timescale 1ns/100ps
`include "nic_regs.vh"
module nic_top
#(
  parameter [`NIC_NUM_IRQ-1:0] PULSE_MASK = 32'h0000_0000 // 1 = pulse
)
(
  input wire ref_clk, // System clock, 20 MHz
  input wire rst, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes all state
  input wire [`NIC_NUM_IRQ-1:0] irq_line, // Peripheral request lines
  input wire reg_sel, // Register access strobe
  input wire reg_wr, // 1 = write, 0 = read
  input wire [`NIC_ADDR_W-1:0] reg_addr, // Byte offset in block
  input wire [31:0] reg_wdata, // Write data
  output reg [31:0] reg_rdata_q, // Read data, one cycle after strobe
  output reg reg_ack_q, // Access done pulse
  input wire core_take, // Core takes the offered interrupt
  input wire core_return, // Core returns from a service routine
  input wire [4:0] core_ret_id, // Number of the routine returning
  output reg irq_req_q, // Interrupt offered to core
  output reg [4:0] irq_id_q, // Number of offered interrupt
  output reg [1:0] irq_prio_q, // Priority of offered interrupt
  output reg [`NIC_NUM_IRQ-1:0] pend_out_q, // Pending state view
  output reg [`NIC_NUM_IRQ-1:0] act_out_q // Active state view
);
  reg [`NIC_NUM_IRQ-1:0] ena_q; // Enable bits
  reg [`NIC_NUM_IRQ-1:0] ena_d;
  reg [2*`NIC_NUM_IRQ-1:0] prio_q; // Two stored bits per interrupt
  reg [2*`NIC_NUM_IRQ-1:0] prio_d;
  wire [`NIC_NUM_IRQ-1:0] pend; // Pending from state machines
  wire [`NIC_NUM_IRQ-1:0] act; // Active from state machines
  wire wr_en; // Qualified write
  wire [`NIC_NUM_IRQ-1:0] wr_set_pend; // Set-pending strobes
  wire [`NIC_NUM_IRQ-1:0] wr_clr_pend; // Clear-pending strobes
  wire [`NIC_NUM_IRQ-1:0] enter_v; // Service entry per irq
  wire [`NIC_NUM_IRQ-1:0] leave_v; // Service return per irq
  wire arb_found; // Arbiter has a winner
  wire [4:0] arb_id; // Arbiter winner
  wire [1:0] arb_prio; // Winner priority
  reg [31:0] rdata_d; // Read mux
  integer k;

  // Priority window decode, used for both read and write
  function prio_hit;
    input [`NIC_ADDR_W-1:0] a;
    begin
      prio_hit = (a >= `NIC_PRIO_BASE_OFS) && (a <= `NIC_PRIO_LAST_OFS)
        && (a[1:0] == 2'b00);
    end
  endfunction

  // Priority register index within the window
  function [2:0] prio_idx;
    input [`NIC_ADDR_W-1:0] a;
    begin
      prio_idx = a[4:2];
    end
  endfunction

  // Lane packing: each byte keeps its top two bits, rest read zero
  function [31:0] prio_word;
    input [2*`NIC_NUM_IRQ-1:0] p;
    input [2:0] idx;
    integer j;
    begin
      prio_word = 32'h0000_0000;
      for (j = 0; j < 4; j = j + 1)
        prio_word[8*j + `NIC_PRIO_LO +: 2] = p[2*(4*idx + j) +: 2];
    end
  endfunction

  // Only whole-word writes are decoded; byte lanes are not split
  assign wr_en = reg_sel & reg_wr & ce;
  assign wr_set_pend = (wr_en && reg_addr == `NIC_SET_PEND_OFS) ?
    reg_wdata : {`NIC_NUM_IRQ{1'b0}};
  assign wr_clr_pend = (wr_en && reg_addr == `NIC_CLR_PEND_OFS) ?
    reg_wdata : {`NIC_NUM_IRQ{1'b0}};

  // Entry goes to the offered interrupt only when the core takes it
  genvar g;
  generate
    for (g = 0; g < `NIC_NUM_IRQ; g = g + 1)
    begin : g_irq
      assign enter_v[g] = core_take & irq_req_q & (irq_id_q == g);
      assign leave_v[g] = core_return & (core_ret_id == g);
      nic_irq_state u_state
      (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .is_pulse(PULSE_MASK[g]),
        .line_in(irq_line[g]),
        .set_pend(wr_set_pend[g]),
        .clr_pend(wr_clr_pend[g]),
        .enter(enter_v[g]),
        .leave(leave_v[g]),
        .pend_q(pend[g]),
        .act_q(act[g])
      );
    end
  endgenerate

  // Candidates must be enabled and pending and not already active
  nic_prio_arb u_arb
  (
    .cand(pend & ena_q & ~act),
    .prio(prio_q),
    .found(arb_found),
    .win_id(arb_id),
    .win_prio(arb_prio)
  );

  // Enable and priority write decode
  always @*
  begin
    // Loop index is given a value on every path, so no latch is inferred
    k = 0;
    ena_d = ena_q;
    prio_d = prio_q;
    if (wr_en && reg_addr == `NIC_SET_ENA_OFS)
      ena_d = ena_q | reg_wdata;
    if (wr_en && reg_addr == `NIC_CLR_ENA_OFS)
      ena_d = ena_q & ~reg_wdata;
    if (wr_en && prio_hit(reg_addr))
    begin
      for (k = 0; k < 4; k = k + 1)
        // Low six bits of each byte are dropped, so 255 stores 192
        prio_d[2*(4*prio_idx(reg_addr) + k) +: 2] =
          reg_wdata[8*k + `NIC_PRIO_LO +: 2];
    end
  end

  // Read mux; unmapped offsets read as zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == `NIC_SET_ENA_OFS || reg_addr == `NIC_CLR_ENA_OFS)
      rdata_d = ena_q;
    else if (reg_addr == `NIC_SET_PEND_OFS ||
             reg_addr == `NIC_CLR_PEND_OFS)
      rdata_d = pend;
    else if (prio_hit(reg_addr))
      rdata_d = prio_word(prio_q, prio_idx(reg_addr));
  end

  // Register state and registered outputs
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ena_q <= `NIC_ENA_RESET;
      prio_q <= {2*`NIC_NUM_IRQ{1'b0}};
      reg_rdata_q <= 32'h0000_0000;
      reg_ack_q <= 1'b0;
      irq_req_q <= 1'b0;
      irq_id_q <= 5'h00;
      irq_prio_q <= 2'h0;
      pend_out_q <= `NIC_PEND_RESET;
      act_out_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ena_q <= ena_d;
      prio_q <= prio_d;
      reg_ack_q <= reg_sel;
      if (reg_sel && !reg_wr)
        reg_rdata_q <= rdata_d;
      // Offer withdrawn the cycle after a take so it is not taken twice
      irq_req_q <= arb_found & ~(core_take & irq_req_q);
      irq_id_q <= arb_id;
      irq_prio_q <= arb_prio;
      pend_out_q <= pend;
      act_out_q <= act;
    end
  end
endmodule

/* tb/nic_assertions.sv */
// Checker for nic_top, bound into every instance of it.
// Assumes ids are captured on take and return strobes.
`timescale 1ns/100ps
module nic_assertions
(
  input wire ref_clk, // Clock
  input wire rst, // Sync reset
  input wire ce, // Clock enable
  input wire reg_sel, // Access strobe
  input wire reg_wr, // Write flag
  input wire reg_ack_q, // Access done
  input wire core_take, // Take pulse
  input wire core_return, // Return pulse
  input wire [4:0] core_ret_id, // Returning number
  input wire irq_req_q, // Offer
  input wire [4:0] irq_id_q, // Offered number
  input wire [31:0] pend_out_q, // Pending view
  input wire [31:0] act_out_q // Active view
);
  reg [4:0] tk_q; // Last taken number
  reg [4:0] rt_q; // Last returned number
  // Views lag the strobes, so the ids are kept here
  always @(posedge ref_clk)
  begin
    if (core_take) tk_q <= irq_id_q;
    if (core_return) rt_q <= core_ret_id;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Accepted take of the offered interrupt
  sequence s_take;
    ce && core_take && irq_req_q;
  endsequence
  AST_ACK: assert property (ce && reg_sel |=> reg_ack_q)
    else $error("access not acked");
  AST_NO_ACK: assert property (ce && !reg_sel |=> !reg_ack_q)
    else $error("ack without access");
  AST_TAKE_DROP: assert property (s_take |=> !irq_req_q)
    else $error("offer kept after take");
  AST_TAKE_ACT: assert property (s_take |=> ##1 act_out_q[tk_q])
    else $error("taken interrupt not active");
  AST_RET: assert property (ce && core_return |=> ##1 !act_out_q[rt_q])
    else $error("returned interrupt still active");
  AST_OFR_PEND: assert property (irq_req_q |-> pend_out_q[irq_id_q])
    else $error("offer not pending");
  AST_OFR_IDLE: assert property (irq_req_q |-> !act_out_q[irq_id_q])
    else $error("active interrupt offered");
  AST_HOLD: assert property (|($past(pend_out_q) & ~pend_out_q) |->
    $past(core_take, 2) || ($past(reg_sel, 2) && $past(reg_wr, 2)))
    else $error("pending lost without cause");
endmodule
bind nic_top nic_assertions u_nic_assertions (.ref_clk(ref_clk),
  .rst(rst), .ce(ce), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_ack_q(reg_ack_q), .core_take(core_take),
  .core_return(core_return), .core_ret_id(core_ret_id),
  .irq_req_q(irq_req_q), .irq_id_q(irq_id_q),
  .pend_out_q(pend_out_q), .act_out_q(act_out_q));

/* tb/nic_core_model.sv */
// Core model: takes the offer, returns after a fixed stay.
// Assumes the offer drops one cycle after an accepted take.
`timescale 1ns/100ps
module nic_core_model
(
  input wire ref_clk, // Clock
  input wire auto_en, // Take offers when high
  input wire irq_req_q, // Offer
  input wire [4:0] irq_id_q, // Offered number
  output reg core_take = 1'b0, // Take pulse
  output reg core_return = 1'b0, // Return pulse
  output reg [4:0] core_ret_id = 5'h00 // Returning number
);
  localparam integer DLY = 20; // Long stay lets pulses land inside
  reg busy_q = 1'b0; // Inside a routine
  reg [4:0] id_q = 5'h00; // Number in service
  integer cnt = 0; // Cycles left
  // One routine at a time; the id shows garbage outside returns
  always @(posedge ref_clk)
  begin
    core_take <= 1'b0;
    core_return <= 1'b0;
    core_ret_id <= ~id_q;
    if (!busy_q && auto_en && irq_req_q)
    begin
      core_take <= 1'b1;
      id_q <= irq_id_q;
      busy_q <= 1'b1;
      cnt <= DLY;
    end
    else if (busy_q && cnt == 0)
    begin
      core_return <= 1'b1;
      core_ret_id <= id_q;
      busy_q <= 1'b0;
    end
    else if (busy_q)
      cnt <= cnt - 1;
  end
endmodule

/* tb/tb_top.sv */
// Testbench: register and interrupt scenarios for nic_top.
// Assumes the core model serves offers once enabled.
`timescale 1ns/100ps
module tb_top;
  reg ref_clk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0; // Drives
  reg auto_en = 1'b0; // Core model serves offers
  reg ce = 1'b1; // Clock enable of the block
  reg [11:0] reg_addr = 12'h000; // Offset
  reg [31:0] irq_line = 32'h0000_0000, reg_wdata = 32'h0000_0000; // Data
  wire reg_ack_q, core_take, core_return, irq_req_q; // Handshakes
  wire [4:0] core_ret_id, irq_id_q; // Numbers
  wire [1:0] irq_prio_q; // Offered priority
  wire [31:0] reg_rdata_q, pend_out_q, act_out_q; // Views
  integer miscompares = 0, n_tests = 0, i, j; // Counters
  always #25 ref_clk = ~ref_clk;
  // Line 8 is pulse type, the rest level type
  nic_top #(.PULSE_MASK(32'h0000_0100)) u_nic_top (.ref_clk(ref_clk),
    .rst(rst), .ce(ce), .irq_line(irq_line), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .core_take(core_take), .core_return(core_return),
    .core_ret_id(core_ret_id), .irq_req_q(irq_req_q),
    .irq_id_q(irq_id_q), .irq_prio_q(irq_prio_q),
    .pend_out_q(pend_out_q), .act_out_q(act_out_q));
  nic_core_model u_nic_core_model (.ref_clk(ref_clk), .auto_en(auto_en),
    .irq_req_q(irq_req_q), .irq_id_q(irq_id_q), .core_take(core_take),
    .core_return(core_return), .core_ret_id(core_ret_id));
  task complete_run;
  begin
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Aligned full-word access; data is scrambled once released
  task acc(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge ref_clk);
    {reg_sel, reg_wr, reg_addr, reg_wdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    {reg_sel, reg_wdata} <= {1'b0, ~d};
    @(negedge ref_clk);
    chk(reg_ack_q, 1);
  end
  endtask
  task rd(input [11:0] a, input [31:0] e);
  begin
    acc(1'b0, a, 32'h0000_0000);
    chk(reg_rdata_q, e);
  end
  endtask
  // One full clock of high level
  task pls(input [4:0] n);
  begin
    @(posedge ref_clk) irq_line[n] <= 1'b1;
    @(posedge ref_clk) irq_line[n] <= 1'b0;
  end
  endtask
  // Bounded wait for a given offer, then its priority is compared
  task wreq(input [4:0] id, input [1:0] p);
  begin
    for (i = 0; i < 80 && !(irq_req_q === 1'b1 && irq_id_q === id); i++)
      @(negedge ref_clk);
    chk({irq_req_q, irq_id_q, irq_prio_q}, {1'b1, id, p});
    if (i == 80) complete_run;
    else repeat (4) @(negedge ref_clk);
  end
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (j = 0; j < 8; j++) rd(12'h400 + 12'(4 * j), 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    $display("reset values done");
    acc(1'b1, 12'h404, 32'hFFFF_FFFF);
    rd(12'h404, 32'hC0C0_C0C0);
    acc(1'b1, 12'h404, 32'h1234_5678);
    rd(12'h404, 32'h0000_4040);
    acc(1'b1, 12'h300, 32'hFFFF_FFFF);
    rd(12'h300, 32'h0000_0000);
    $display("priority fields done");
    acc(1'b1, 12'h200, 32'h0000_0020);
    rd(12'h200, 32'h0000_0020);
    chk(irq_req_q, 0);
    pls(5'd8);
    repeat (2) @(negedge ref_clk);
    chk(pend_out_q, 32'h0000_0120);
    acc(1'b1, 12'h280, 32'h0000_0120);
    repeat (2) @(negedge ref_clk);
    chk(pend_out_q, 32'h0000_0000);
    @(posedge ref_clk) irq_line[3] <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(pend_out_q, 32'h0000_0008);
    acc(1'b1, 12'h280, 32'h0000_0008);
    repeat (2) @(negedge ref_clk);
    chk(pend_out_q, 32'h0000_0008);
    $display("pending control done");
    acc(1'b1, 12'h400, 32'h4000_0000);
    acc(1'b1, 12'h404, 32'h0000_0000);
    acc(1'b1, 12'h200, 32'h0000_0020);
    acc(1'b1, 12'h100, 32'h0000_0128);
    wreq(5'd5, 2'd0);
    auto_en <= 1'b1;
    wreq(5'd3, 2'd1);
    // Let line 3 enter service first, so the next offer is a re-pend
    repeat (20) @(negedge ref_clk);
    chk({irq_req_q, act_out_q[3]}, 2'b01);
    wreq(5'd3, 2'd1);
    @(posedge ref_clk) irq_line[3] <= 1'b0;
    repeat (60) @(negedge ref_clk);
    chk(pend_out_q | act_out_q, 32'h0000_0000);
    $display("level service done");
    pls(5'd8);
    wreq(5'd8, 2'd0);
    pls(5'd8);
    repeat (2) @(negedge ref_clk);
    chk({pend_out_q[8], act_out_q[8]}, 2'b11);
    acc(1'b1, 12'h280, 32'h0000_0100);
    repeat (2) @(negedge ref_clk);
    chk({pend_out_q[8], act_out_q[8]}, 2'b01);
    repeat (40) @(negedge ref_clk);
    chk(pend_out_q | act_out_q, 32'h0000_0000);
    $display("pulse service done");
    // A pulse that comes and goes while frozen is never sampled
    @(posedge ref_clk) ce <= 1'b0;
    pls(5'd8);
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(pend_out_q | act_out_q, 32'h0000_0000);
    $display("clock enable done");
    complete_run;
  end
endmodule
